// ==== rtl/cfsc_channel.sv ====
/*
 * One channel's fail status flags, 32-bit fail counter with snapshot and
 * staged preload, plus the channel/common/reserved address decode.
 * Assumes register bus signals already retimed to the master clock by the
 * bus front end; error and fail event inputs are on the same clock.
 */
`default_nettype none
module cfsc_channel #(
    parameter int CH_INDEX = 0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [4:0] reg_select,
    input wire logic [4:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_hit,
    output logic common_access,
    output logic reserved_access,
    input wire logic long_edge_err,
    input wire logic order_err,
    input wire logic same_edge_err,
    input wire logic adder_overflow,
    input wire logic vernier_close_err,
    input wire logic [3:0] edge_fail,
    input wire logic win01_fail,
    input wire logic win23_fail,
    input wire logic [2:0] fail_events,
    output logic fail_mask
);
    // ****************************************************************
    // Decode
    // ****************************************************************
    logic ch_sel;
    logic in_ch_space;
    logic wr_low;
    logic wr_high;
    logic rd_low;
    logic wr_dyn;
    assign ch_sel = reg_select[CH_INDEX];
    // Channel space decode
    // channel offsets
    assign in_ch_space = (reg_addr <= cfsc_pkg::OFF_CH_LAST);
    assign reserved_access = (reg_read | reg_write) & ch_sel
        & (reg_addr >= cfsc_pkg::OFF_RSVD_FIRST) & (reg_addr <= cfsc_pkg::OFF_RSVD_LAST);
    assign common_access = (reg_read | reg_write) & reg_select[cfsc_pkg::SEL_COMMON]
        & (reg_addr >= cfsc_pkg::OFF_COMMON_FIRST);
    assign reg_hit = ch_sel & in_ch_space & (reg_read | reg_write);
    assign wr_low = reg_hit & reg_write & (reg_addr == cfsc_pkg::OFF_CNT_LOW);
    assign wr_high = reg_hit & reg_write & (reg_addr == cfsc_pkg::OFF_CNT_HIGH);
    assign rd_low = reg_hit & reg_read & (reg_addr == cfsc_pkg::OFF_CNT_LOW);
    assign wr_dyn = reg_hit & reg_write & (reg_addr == cfsc_pkg::OFF_DYN_CFG);
    // ****************************************************************
    // Dynamic configuration: mask and increment
    // ****************************************************************
    logic [15:0] dyn_reg;
    logic inc_pulse_reg;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            dyn_reg <= cfsc_pkg::DYN_RESET;
        end else if (wr_dyn) begin
            dyn_reg <= reg_wdata & cfsc_pkg::DYN_RW_MASK;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            inc_pulse_reg <= 1'b0;
        end else begin
            inc_pulse_reg <= wr_dyn & reg_wdata[cfsc_pkg::BIT_DYN_INC];
        end
    end
    assign fail_mask = dyn_reg[cfsc_pkg::BIT_DYN_MASK];
    // ****************************************************************
    // Status flags
    // ****************************************************************
    logic long_edge_reg;
    logic order_err_reg;
    logic adder_ovf_reg;
    logic too_close_reg;
    logic [3:0] fail_acc_reg;
    logic [3:0] fail_hit;
    logic [15:0] status_word;
    assign fail_hit = {edge_fail[3] | win23_fail, edge_fail[2],
                       edge_fail[1] | win01_fail, edge_fail[0]};
    // Sticky flags; no software clear, so an event can never be lost to one
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            long_edge_reg <= cfsc_pkg::STATUS_RESET[cfsc_pkg::BIT_LONG_EDGE];
        end else if (long_edge_err) begin
            long_edge_reg <= 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            order_err_reg <= cfsc_pkg::STATUS_RESET[cfsc_pkg::BIT_ORDER_ERR];
        end else if (order_err | same_edge_err) begin
            order_err_reg <= 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            adder_ovf_reg <= cfsc_pkg::STATUS_RESET[cfsc_pkg::BIT_ADDER_OVF];
        end else if (adder_overflow) begin
            adder_ovf_reg <= 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            too_close_reg <= cfsc_pkg::STATUS_RESET[cfsc_pkg::BIT_TOO_CLOSE];
        end else if (vernier_close_err) begin
            too_close_reg <= 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fail_acc_reg <= cfsc_pkg::STATUS_RESET[3:0];
        end else if (!fail_mask) begin
            fail_acc_reg <= fail_acc_reg | fail_hit;
        end
    end
    // unused bits keep their zero reset value
    always_comb begin
        status_word = cfsc_pkg::STATUS_RESET;
        status_word[cfsc_pkg::BIT_LONG_EDGE] = long_edge_reg;
        status_word[cfsc_pkg::BIT_ORDER_ERR] = order_err_reg;
        status_word[cfsc_pkg::BIT_ADDER_OVF] = adder_ovf_reg;
        status_word[cfsc_pkg::BIT_TOO_CLOSE] = too_close_reg;
        status_word[3:0] = fail_acc_reg;
    end
    // ****************************************************************
    // Fail counter
    // ****************************************************************
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic [31:0] snap_reg;
    logic [15:0] stage_low_reg;
    logic [2:0] inc_total;
    // up to four fails per period plus the software pulse
    assign inc_total = (fail_events > 3'(cfsc_pkg::MAX_FAILS_PER_PERIOD)
        ? 3'(cfsc_pkg::MAX_FAILS_PER_PERIOD) : fail_events) + {2'b00, inc_pulse_reg};
    always_comb begin
        count_next = count_reg;
        if (!fail_mask) begin
            count_next = count_reg + 32'(inc_total);
        end
        if (wr_high) begin
            count_next = {reg_wdata, stage_low_reg};
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count_reg <= cfsc_pkg::COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            snap_reg <= cfsc_pkg::COUNT_RESET;
        end else if (rd_low) begin
            snap_reg <= count_reg;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stage_low_reg <= cfsc_pkg::COUNT_RESET[15:0];
        end else if (wr_low) begin
            stage_low_reg <= reg_wdata;
        end
    end
    // ****************************************************************
    // Read data, registered
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (!(reg_hit & reg_read)) begin
            reg_rdata <= 16'h0000;
        end else begin
            case (reg_addr)
                cfsc_pkg::OFF_STATUS: reg_rdata <= status_word;
                cfsc_pkg::OFF_CNT_LOW: reg_rdata <= count_reg[15:0];
                cfsc_pkg::OFF_CNT_HIGH: reg_rdata <= snap_reg[31:16];
                cfsc_pkg::OFF_DYN_CFG: reg_rdata <= dyn_reg;
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end
endmodule // cfsc_channel
`default_nettype wire

// ==== rtl/cfsc_pkg.sv ====
/*
 * Constants for the per-channel fail status and fail counter block.
 * Assumes a single master clock domain shared by the register port and fail logic.
 */
`default_nettype none
package cfsc_pkg;
    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int NUM_CH = 4;
    localparam int SEL_W = 5;
    localparam logic [4:0] OFF_STATUS = 5'h00;
    localparam logic [4:0] OFF_CNT_LOW = 5'h01;
    localparam logic [4:0] OFF_CNT_HIGH = 5'h02;
    localparam logic [4:0] OFF_DYN_CFG = 5'h04;
    localparam logic [4:0] OFF_CH_LAST = 5'h12;
    localparam logic [4:0] OFF_RSVD_FIRST = 5'h13;
    localparam logic [4:0] OFF_RSVD_LAST = 5'h18;
    localparam logic [4:0] OFF_COMMON_FIRST = 5'h19;
    localparam logic [4:0] OFF_COMMON_LAST = 5'h1F;
    // ****************************************************************
    // Select bits inside the five-bit block select
    // ****************************************************************
    localparam int SEL_COMMON = 4;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_LONG_EDGE = 7;
    localparam int BIT_ORDER_ERR = 6;
    localparam int BIT_ADDER_OVF = 5;
    localparam int BIT_TOO_CLOSE = 4;
    localparam int BIT_DYN_MASK = 2;
    localparam int BIT_DYN_INC = 0;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [15:0] DYN_RESET = 16'h0000;
    localparam logic [15:0] DYN_RW_MASK = 16'h0004;
    localparam int MAX_FAILS_PER_PERIOD = 4;
endpackage : cfsc_pkg
`default_nettype wire

// ==== verif/cfsc_host.sv ====
/* Host on the register bus, one-cycle strobes after a clock edge.
   Assumes one access at a time. */
`default_nettype none
module cfsc_host (
    input wire logic clock,
    input wire logic [15:0] reg_rdata,
    output var logic reg_write,
    output var logic reg_read,
    output var logic [4:0] reg_select,
    output var logic [4:0] reg_addr,
    output var logic [15:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********
    // Bus cycles
    // ********
    initial {reg_select, reg_addr, reg_write, reg_read, reg_wdata} = '0;
    // Released select and write data lines flip, address holds, so stale data never looks valid
    task automatic wr(input logic [4:0] s, a, input logic [15:0] v);
        @(posedge clock);
        {reg_select, reg_addr, reg_wdata, reg_write} <= {s, a, v, 1'b1};
        @(posedge clock);
        {reg_select, reg_wdata, reg_write} <= {~s, ~v, 1'b0};
    endtask
    task automatic rd(input logic [4:0] s, a, output logic [15:0] v);
        @(posedge clock);
        {reg_select, reg_addr, reg_read} <= {s, a, 1'b1};
        @(posedge clock);
        {reg_select, reg_read} <= {~s, 1'b0};
        @(posedge clock);
        v = reg_rdata;
    endtask
endmodule // cfsc_host
`default_nettype wire

// ==== verif/cfsc_props.sv ====
/* Checker on one fail status channel's ports.
   Assumes a bind from the bench top; one clock. */
`default_nettype none
module cfsc_props #(
    parameter int CH_INDEX = 0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic reg_hit,
    input wire logic reserved_access,
    input wire logic common_access,
    input wire logic long_edge_err,
    input wire logic order_err,
    input wire logic same_edge_err,
    input wire logic adder_overflow,
    input wire logic vernier_close_err,
    input wire logic [4:0] reg_select,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********
    // Checks
    // ********
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence stat_rd; reg_read && reg_select[CH_INDEX] && reg_addr == 5'h00; endsequence
    // Flag must show on a status read 2 to 40 cycles after the event
    property sticky(ev, int b); ev ##[2:40] stat_rd |=> reg_rdata[b]; endproperty
    AST_HIT: assert property (reg_hit == ((reg_read || reg_write) && reg_select[CH_INDEX]
        && reg_addr <= 5'h12)) else $error("hit decode wrong");
    AST_RSVD: assert property (reg_read && reg_select[CH_INDEX] && reg_addr == 5'h13
        |-> reserved_access) else $error("reserved not flagged");
    AST_COMMON: assert property (common_access == ((reg_read || reg_write)
        && reg_select[4] && reg_addr >= 5'h19)) else $error("common decode wrong");
    AST_QUIET: assert property (!(reg_read && reg_select[CH_INDEX])
        |=> reg_rdata == 16'h0000) else $error("read data not idle");
    AST_LONG: assert property (sticky(long_edge_err, 7)) else $error("bit 7 not set");
    AST_ORDER: assert property (sticky(order_err, 6)) else $error("bit 6 not set");
    AST_SAME: assert property (sticky(same_edge_err, 6)) else $error("bit 6 not set");
    AST_OVF: assert property (sticky(adder_overflow, 5)) else $error("bit 5 not set");
    AST_CLOSE: assert property (sticky(vernier_close_err, 4)) else $error("bit 4 not set");
endmodule // cfsc_props
`default_nettype wire

// ==== verif/testbench.sv ====
/* Bench for channel 0 through the host model.
   Assumes the checker bind below. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, reset_n, reg_write, reg_read, reg_hit, common_access, reserved_access, fail_mask;
    logic [4:0] reg_select, reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [10:0] ev;
    logic [2:0] fail_events;
    int err_total, compares, cyc;
    cfsc_host u_cfsc_host (
        .clock(clock),
        .reg_rdata(reg_rdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_select(reg_select),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata)
    );
    cfsc_channel #(.CH_INDEX(0)) u_cfsc_channel (
        .clock(clock),
        .reset_n(reset_n),
        .reg_select(reg_select),
        .reg_addr(reg_addr),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_hit(reg_hit),
        .common_access(common_access),
        .reserved_access(reserved_access),
        .long_edge_err(ev[0]),
        .order_err(ev[1]),
        .same_edge_err(ev[2]),
        .adder_overflow(ev[3]),
        .vernier_close_err(ev[4]),
        .edge_fail(ev[8:5]),
        .win01_fail(ev[9]),
        .win23_fail(ev[10]),
        .fail_events(fail_events),
        .fail_mask(fail_mask)
    );
    // ********
    // Clock and reporting
    // ********
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic print_verdict;
        if (err_total == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic do_reset;
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic flag_scn;
        int b[11] = '{7, 6, 6, 5, 4, 0, 1, 2, 3, 1, 3};
        for (int i = 0; i < 11; i++) begin
            do_reset();
            @(posedge clock);
            ev <= 11'h001 << i;
            @(posedge clock);
            ev <= 11'h000;
            // Second read proves the flag is sticky
            repeat (2) begin
                u_cfsc_host.rd(5'h01, 5'h00, d);
                chk("status", 16'h0001 << b[i], d);
            end
        end
    endtask
    task automatic count_scn;
        do_reset();
        @(posedge clock);
        fail_events <= 3'h3;
        repeat (2) @(posedge clock);
        fail_events <= 3'h4;
        @(posedge clock);
        fail_events <= 3'h0;
        u_cfsc_host.rd(5'h01, 5'h01, d);
        chk("cnt_low", 16'h000A, d);
        u_cfsc_host.wr(5'h01, 5'h01, 16'hFFFE);
        u_cfsc_host.wr(5'h01, 5'h02, 16'h0001);
        repeat (2) u_cfsc_host.wr(5'h01, 5'h04, 16'h0001);
        u_cfsc_host.rd(5'h01, 5'h01, d);
        chk("cnt_low", 16'h0000, d);
        @(posedge clock);
        fail_events <= 3'h3;
        @(posedge clock);
        fail_events <= 3'h0;
        u_cfsc_host.rd(5'h01, 5'h02, d);
        chk("snap_high", 16'h0002, d);
        u_cfsc_host.rd(5'h01, 5'h01, d);
        chk("live_low", 16'h0003, d);
    endtask
    task automatic mask_scn;
        logic [25:0] t[6] = '{{5'h01, 5'h04, 16'h0004}, {5'h02, 5'h04, 16'h0000},
            {5'h01, 5'h00, 16'h0000}, {5'h01, 5'h01, 16'h0000}, {5'h01, 5'h13, 16'h0000},
            {5'h10, 5'h19, 16'h0000}};
        do_reset();
        u_cfsc_host.wr(5'h0F, 5'h04, 16'h0004);
        #1 chk("mask", 16'h0001, {15'h0000, fail_mask});
        @(posedge clock);
        {ev, fail_events} <= {11'h1E0, 3'h3};
        @(posedge clock);
        {ev, fail_events} <= '0;
        u_cfsc_host.wr(5'h01, 5'h04, 16'h0005);
        foreach (t[i]) begin
            u_cfsc_host.rd(t[i][25:21], t[i][20:16], d);
            chk("masked read", t[i][15:0], d);
        end
    endtask
    initial begin
        {reset_n, ev, fail_events} = '0;
        flag_scn();
        count_scn();
        mask_scn();
        print_verdict();
    end
endmodule // testbench
bind cfsc_channel cfsc_props #(.CH_INDEX(CH_INDEX)) u_cfsc_props (
    .clock(clock),
    .reset_n(reset_n),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_hit(reg_hit),
    .reserved_access(reserved_access),
    .common_access(common_access),
    .long_edge_err(long_edge_err),
    .order_err(order_err),
    .same_edge_err(same_edge_err),
    .adder_overflow(adder_overflow),
    .vernier_close_err(vernier_close_err),
    .reg_select(reg_select),
    .reg_addr(reg_addr),
    .reg_rdata(reg_rdata)
);
`default_nettype wire
